// [logic/msc_step_cfg.sv]
// apb register bank for sequencer step seven of the aux mux converter
// assumes an apb master on pclk and a sequencer that pulses step start and done
// Operation
// - register at index 97h, resets 0007h
// - bit 15 includes step in run
// - bits 14:13 select gain 1/2/4
// - bit 4 picks ground or aux seven
// - bits 3:0 codes 0..7 pick aux inputs
// - codes 8 upward pick internal sources
// - internal source forces automatic negative input
//
// The implementer's own choice: the APB register port.
module msc_step_cfg
	import msc_pkg::*;
(
	input wire logic pclk, // bus clock, 10 MHz
	input wire logic presetn, // asynchronous reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction, high for write
	input wire logic [11:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	input wire logic [3:0] pstrb, // apb byte strobes
	output logic pready, // apb ready, zero wait
	output logic [31:0] prdata, // apb read data
	output logic pslverr, // apb error on unmapped address
	input wire logic step_start, // sequencer begins step seven, pulse
	input wire logic step_done, // sequencer ends step seven, pulse
	output logic step_seven_enable, // step is part of the run
	output msc_pkg::msc_gain_t step_gain, // effective gain
	output msc_pkg::msc_neg_t step_negative, // effective negative input
	output logic [3:0] step_seven_positive_select, // positive input code
	output logic step_positive_internal, // positive input is internal
	output logic step_busy // step seven conversion in progress
);
	import msc_pkg::*;

	logic [15:0] cfg_r;
	logic [15:0] cfg_nxt;
	logic [15:0] strb_mask;
	logic [31:0] rdata_nxt;
	logic hit_cfg;
	logic hit_stat;
	logic setup;
	logic access;
	logic err_r;
	msc_snap_t snap_r;
	msc_snap_t snap_nxt;
	logic en_r;
	msc_gain_t gain_r;
	msc_neg_t neg_r;
	logic [3:0] pos_r;
	logic int_r;
	logic [15:0] stat_word;

	msc_sel_if sel ();

	// bus phase decode
	assign setup = psel & ~penable;
	assign access = psel & penable;
	assign hit_cfg = (paddr == MSC_CFG_ADDR);
	assign hit_stat = (paddr == MSC_STAT_ADDR);

	// zero-wait slave: every access phase completes at once
	assign pready = access;
	assign pslverr = access & err_r;

	// byte strobes widen to a bit mask over the low half word
	assign strb_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

	always_comb
	begin
		cfg_nxt = cfg_r;
		if (access && pwrite && hit_cfg)
			cfg_nxt = (cfg_r & ~(strb_mask & MSC_CFG_WMASK)) | (pwdata[15:0] & strb_mask & MSC_CFG_WMASK);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cfg_r <= MSC_CFG_RESET;
		else
			cfg_r <= cfg_nxt;
	end

	// unmapped addresses flagged in setup so the error stands through access
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			err_r <= 1'b0;
		else if (setup)
			err_r <= ~(hit_cfg | hit_stat);
	end

	// status word shows what the sequencer is actually using
	always_comb
	begin
		stat_word = 16'h0000;
		stat_word[MSC_ST_BUSY_BIT] = (snap_r == MSC_SNAP_HOLD);
		stat_word[MSC_ST_NEG_HI:MSC_ST_NEG_LO] = neg_r;
		stat_word[MSC_ST_INT_BIT] = int_r;
		stat_word[MSC_ST_GAIN_HI:MSC_ST_GAIN_LO] = gain_r;
	end

	// read data chosen in setup; nothing else writes cfg during a read
	always_comb
	begin
		rdata_nxt = 32'h0000_0000;
		if (hit_cfg)
			rdata_nxt = {16'h0000, cfg_r};
		else if (hit_stat)
			rdata_nxt = {16'h0000, stat_word};
	end

	// prdata from a flop, loaded in the setup of a read
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (setup && !pwrite)
			prdata <= rdata_nxt;
	end

	assign sel.gain_field = cfg_r[MSC_GAIN_HI:MSC_GAIN_LO];
	assign sel.neg_field = cfg_r[MSC_NEG_BIT];
	assign sel.pos_field = cfg_r[MSC_POS_HI:MSC_POS_LO];

	msc_step_decode u_decode
	(
		.sel (sel.dec)
	);

	// snapshot state: a step in flight keeps the selection it started with
	always_comb
	begin
		snap_nxt = snap_r;
		unique case (snap_r)
			MSC_SNAP_IDLE:
			begin
				if (step_start && cfg_r[MSC_EN_BIT])
					snap_nxt = MSC_SNAP_HOLD;
			end
			MSC_SNAP_HOLD:
			begin
				if (step_done)
					snap_nxt = MSC_SNAP_IDLE;
			end
			default:
				snap_nxt = MSC_SNAP_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			snap_r <= MSC_SNAP_IDLE;
		else
			snap_r <= snap_nxt;
	end

	// selections follow the register while idle and freeze during a step,
	// trading one cycle of lag for a glitch-free mux during conversion
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			gain_r <= MSC_GAIN_X1;
			neg_r <= MSC_NEG_GROUND;
			pos_r <= MSC_CFG_RESET[MSC_POS_HI:MSC_POS_LO];
			int_r <= 1'b0;
		end
		else if (snap_r == MSC_SNAP_IDLE)
		begin
			gain_r <= sel.gain;
			neg_r <= sel.neg;
			pos_r <= sel.pos_field;
			int_r <= sel.pos_internal;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			en_r <= 1'b0;
		else
			en_r <= cfg_r[MSC_EN_BIT];
	end

	// outputs straight from flops, except step_busy, decoded from the snapshot state
	assign step_seven_enable = en_r;
	assign step_gain = gain_r;
	assign step_negative = neg_r;
	assign step_seven_positive_select = pos_r;
	assign step_positive_internal = int_r;
	assign step_busy = (snap_r == MSC_SNAP_HOLD);

endmodule : msc_step_cfg

// [logic/msc_pkg.sv]
// constants, field layout and encodings for the step-seven configuration bank
// assumes an apb slave with 32-bit data and 12-bit byte addresses
package msc_pkg;

	// register indices; byte address is four times the index
	localparam logic [9:0] MSC_CFG_INDEX = 10'h097;
	localparam logic [9:0] MSC_STAT_INDEX = 10'h09F;
	localparam logic [11:0] MSC_CFG_ADDR = {MSC_CFG_INDEX, 2'b00};
	localparam logic [11:0] MSC_STAT_ADDR = {MSC_STAT_INDEX, 2'b00};

	// configuration word layout
	localparam int MSC_EN_BIT = 15;
	localparam int MSC_GAIN_HI = 14;
	localparam int MSC_GAIN_LO = 13;
	localparam int MSC_NEG_BIT = 4;
	localparam int MSC_POS_HI = 3;
	localparam int MSC_POS_LO = 0;
	localparam logic [15:0] MSC_CFG_RESET = 16'h0007;
	localparam logic [15:0] MSC_CFG_WMASK = 16'hE01F;

	// positive codes at or above this value pick an internal source
	localparam logic [3:0] MSC_POS_FIRST_INTERNAL = 4'h8;

	// status word layout
	localparam int MSC_ST_BUSY_BIT = 0;
	localparam int MSC_ST_NEG_LO = 1;
	localparam int MSC_ST_NEG_HI = 2;
	localparam int MSC_ST_INT_BIT = 3;
	localparam int MSC_ST_GAIN_LO = 4;
	localparam int MSC_ST_GAIN_HI = 5;

	// effective converter gain
	typedef enum logic [1:0]
	{
		MSC_GAIN_X1 = 2'h0,
		MSC_GAIN_X2 = 2'h1,
		MSC_GAIN_X4 = 2'h2
	} msc_gain_t;

	// effective negative input
	typedef enum logic [1:0]
	{
		MSC_NEG_GROUND = 2'h0,
		MSC_NEG_AUX7 = 2'h1,
		MSC_NEG_AUTO = 2'h2
	} msc_neg_t;

	// snapshot state while the sequencer works on step seven
	typedef enum logic [1:0]
	{
		MSC_SNAP_IDLE = 2'h0,
		MSC_SNAP_HOLD = 2'h1
	} msc_snap_t;

endpackage : msc_pkg

// [logic/msc_sel_if.sv]
// carries raw step fields to the decoder and decoded selections back
// assumes both ends sit in the same clock domain
interface msc_sel_if;
	import msc_pkg::*;

	logic [1:0] gain_field;
	logic neg_field;
	logic [3:0] pos_field;
	msc_gain_t gain;
	msc_neg_t neg;
	logic pos_internal;

	// register side drives fields, decoder answers
	modport src (output gain_field, output neg_field, output pos_field,
		input gain, input neg, input pos_internal);
	modport dec (input gain_field, input neg_field, input pos_field,
		output gain, output neg, output pos_internal);

endinterface : msc_sel_if

// [logic/msc_step_decode.sv]
// turns the stored step fields into effective gain and input selections
// assumes purely combinational use; the caller registers the results
module msc_step_decode
(
	msc_sel_if.dec sel // fields in, decoded selections out
);
	import msc_pkg::*;

	assign sel.pos_internal = (sel.pos_field >= MSC_POS_FIRST_INTERNAL);

	always_comb
	begin
		unique case (sel.gain_field)
			2'h0: sel.gain = MSC_GAIN_X1;
			2'h1: sel.gain = MSC_GAIN_X2;
			2'h2: sel.gain = MSC_GAIN_X4;
			2'h3: sel.gain = MSC_GAIN_X4; // both upper codes mean four
		endcase
	end

	always_comb
	begin
		if (sel.pos_internal)
			sel.neg = MSC_NEG_AUTO; // negative select bit ignored here
		else if (sel.neg_field)
			sel.neg = MSC_NEG_AUX7;
		else
			sel.neg = MSC_NEG_GROUND;
	end

endmodule : msc_step_decode

// [testbench/msc_step_cfg_properties.sv]
// checker for the step-seven bank, sees only its ports
// assumes one clock domain and the package constants
module msc_props
(
	input wire logic pclk, // bus clock
	input wire logic presetn, // reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic pready, // apb ready
	input wire logic pslverr, // apb error
	input wire logic step_start, // step begins, pulse
	input wire logic step_done, // step ends, pulse
	input wire logic step_seven_enable, // step is in the run
	input wire logic step_positive_internal, // positive input is internal
	input wire logic step_busy, // step in flight
	input wire logic [11:0] paddr, // byte address
	input wire logic [31:0] pwdata, // write data
	input wire logic [31:0] prdata, // read data
	input wire logic [3:0] pstrb, // byte strobes
	input wire logic [3:0] step_seven_positive_select, // positive code
	input wire msc_pkg::msc_gain_t step_gain, // effective gain
	input wire msc_pkg::msc_neg_t step_negative // effective negative input
);
	timeunit 1ns;
	timeprecision 1ns;
	import msc_pkg::*;

	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// idle writes only; a busy step holds its snapshot
	sequence s_wr;
		psel && penable && pwrite && paddr == MSC_CFG_ADDR && pstrb[1] && !step_busy && !step_start;
	endsequence
	sequence s_hold;
		step_busy ##1 step_busy;
	endsequence
	property p_rst;
		$rose(presetn) |-> step_seven_positive_select == 4'h7 && !step_seven_enable;
	endproperty
	a_rst: assert property (p_rst) else $error("bad reset value");
	property p_rdy;
		psel && penable |-> pready && pslverr == (paddr != MSC_CFG_ADDR && paddr != MSC_STAT_ADDR);
	endproperty
	a_rdy: assert property (p_rdy) else $error("bad bus answer");
	property p_en;
		s_wr |-> ##2 step_seven_enable == $past(pwdata[15], 2);
	endproperty
	a_en: assert property (p_en) else $error("enable not stored");
	property p_hold;
		s_hold |-> $stable(step_gain) && $stable(step_negative);
	endproperty
	a_hold: assert property (p_hold) else $error("selection moved while busy");
	property p_done;
		step_busy && step_done |=> !step_busy;
	endproperty
	a_done: assert property (p_done) else $error("busy stuck");
	property p_start;
		$rose(step_busy) |-> $past(step_start);
	endproperty
	a_start: assert property (p_start) else $error("busy without start");
	property p_gain;
		step_gain != 2'h3;
	endproperty
	a_gain: assert property (p_gain) else $error("bad gain code");
	property p_int;
		step_positive_internal == (step_seven_positive_select >= MSC_POS_FIRST_INTERNAL);
	endproperty
	a_int: assert property (p_int) else $error("bad internal flag");
	property p_auto;
		step_positive_internal |-> step_negative == MSC_NEG_AUTO;
	endproperty
	a_auto: assert property (p_auto) else $error("negative not automatic");
	property p_rd;
		psel && penable && !pwrite && paddr == MSC_CFG_ADDR |-> prdata[31:16] == 16'h0 && prdata[12:5] == 8'h0;
	endproperty
	a_rd: assert property (p_rd) else $error("reserved bits set");
endmodule : msc_props
bind msc_step_cfg msc_props i_chk
(
	.pclk (pclk),
	.presetn (presetn),
	.psel (psel),
	.penable (penable),
	.pwrite (pwrite),
	.pready (pready),
	.pslverr (pslverr),
	.step_start (step_start),
	.step_done (step_done),
	.step_seven_enable (step_seven_enable),
	.step_positive_internal (step_positive_internal),
	.step_busy (step_busy),
	.paddr (paddr),
	.pwdata (pwdata),
	.prdata (prdata),
	.pstrb (pstrb),
	.step_seven_positive_select (step_seven_positive_select),
	.step_gain (step_gain),
	.step_negative (step_negative)
);

// [testbench/tb.sv]
// self-checking bench for the step-seven bank
// assumes a zero-wait apb slave on one 10 MHz clock
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import msc_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, step_start = 0, step_done = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rdat;
	logic [3:0] pstrb = 4'h3, step_seven_positive_select;
	logic pready, pslverr, step_seven_enable, step_positive_internal, step_busy, rerr;
	msc_gain_t step_gain;
	msc_neg_t step_negative;
	int bad_count = 0, checks_done = 0;
	always #50 pclk = ~pclk;
	msc_step_cfg i_dut
	(
		.pclk (pclk),
		.presetn (presetn),
		.psel (psel),
		.penable (penable),
		.pwrite (pwrite),
		.paddr (paddr),
		.pwdata (pwdata),
		.pstrb (pstrb),
		.pready (pready),
		.prdata (prdata),
		.pslverr (pslverr),
		.step_start (step_start),
		.step_done (step_done),
		.step_seven_enable (step_seven_enable),
		.step_gain (step_gain),
		.step_negative (step_negative),
		.step_seven_positive_select (step_seven_positive_select),
		.step_positive_internal (step_positive_internal),
		.step_busy (step_busy)
	);
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp
	task stop_test;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : stop_test
	// one apb transfer; a spare edge first keeps drives apart
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rdat = prdata;
		rerr = pslverr;
		psel <= 0;
		penable <= 0;
		if (pready !== 1'b1)
		begin
			bad_count++;
			$display("CHECK FAILED %0t no ready from slave", $time);
			stop_test();
		end
	endtask : xfer
	// outputs follow the store one edge later
	task wcfg(input logic [15:0] d);
		xfer(1, MSC_CFG_ADDR, {16'h0, d});
		repeat (2) @(posedge pclk);
	endtask : wcfg
	initial
	begin
		repeat (5) @(posedge pclk);
		presetn <= 1;
		xfer(0, MSC_CFG_ADDR, 0);
		cmp(rdat, 32'h7);
		xfer(0, 12'h010, 0);
		cmp({rdat[30:0], rerr}, 32'h1);
		// reserved bits dropped
		wcfg(16'hFFFF);
		xfer(0, MSC_CFG_ADDR, 0);
		cmp(rdat, 32'hE01F);
		// low strobe only: enable and gain must survive
		pstrb <= 4'h1;
		wcfg(16'h0000);
		pstrb <= 4'h3;
		// status is read-only: write dropped without error
		xfer(1, MSC_STAT_ADDR, 32'hFFFF);
		cmp(rerr, 0);
		xfer(0, MSC_CFG_ADDR, 0);
		cmp(rdat, 32'hE000);
		for (int g = 0; g < 4; g++)
		begin
			wcfg({1'b0, g[1:0], 8'h0, 1'b1, 4'h3});
			cmp(step_gain, g > 1 ? MSC_GAIN_X4 : g);
			cmp(step_negative, MSC_NEG_AUX7);
		end
		for (int p = 0; p < 16; p++)
		begin
			wcfg({3'b100, 8'h0, p[0], p[3:0]});
			cmp(step_seven_positive_select, p);
			cmp(step_positive_internal, p > 7);
			cmp(step_negative, p > 7 ? MSC_NEG_AUTO : p[0] ? MSC_NEG_AUX7 : MSC_NEG_GROUND);
			cmp(step_seven_enable, 1);
		end
		step_start <= 1;
		@(posedge pclk);
		step_start <= 0;
		wcfg(16'h2001);
		cmp({step_busy, step_gain}, {1'b1, MSC_GAIN_X1});
		// status shows the frozen internal selection: busy, auto negative, internal, gain one
		xfer(0, MSC_STAT_ADDR, 0);
		cmp(rdat, {26'h0, MSC_GAIN_X1, 1'b1, MSC_NEG_AUTO, 1'b1});
		step_done <= 1;
		@(posedge pclk);
		step_done <= 0;
		repeat (3) @(posedge pclk);
		cmp({step_busy, step_gain}, {1'b0, MSC_GAIN_X2});
		step_start <= 1;
		@(posedge pclk);
		step_start <= 0;
		repeat (2) @(posedge pclk);
		cmp(step_busy, 0);
		stop_test();
	end
endmodule : tb
